/* File: design/ccsc_top.sv */
`timescale 1ns/10ps
`include "ccsc_consts.svh"
// clock mode controller with system counter
module ccsc_top import ccsc_pkg::*; #(
    parameter int SWITCH_CYC = `CCSC_SWITCH_CYC,
    parameter int CNT_WIDTH = 32,
    parameter int CORES = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // oscillator and pll controls
    output logic oscillator_enable_out,
    output logic [1:0] oscillator_gain_out,
    output logic oscillator_output_pin_oe_n_out,
    output logic pll_enable_out,
    output logic [2:0] pll_tap_out,
    output logic pll_reference_out,
    // system clock mux select
    output logic [2:0] clock_source_out,
    output logic switching_out,
    output logic config_error_out,
    // counter to every core
    output logic [CORES*CNT_WIDTH-1:0] core_count_out
);
    localparam int SW_W = $clog2(SWITCH_CYC + 1);

    ccsc_cfg_t cfg_q, cfg_d;
    ccsc_src_t src_q, src_d;
    ccsc_state_t st_q, st_d;
    logic [SW_W-1:0] tmr_q, tmr_d;
    logic [31:0] rdata_q, rdata_d;
    logic [CNT_WIDTH-1:0] count;
    ccsc_src_t want;
    logic cfg_bad;

    initial begin
        if (SWITCH_CYC < 1) $error("switch count too small");
        if (CNT_WIDTH != 32) $error("counter must be 32 bits");
        if (CORES < 1) $error("need a core");
    end

    ccsc_counter #(.WIDTH(CNT_WIDTH)) u_cnt (
        .clk_in(clk_in),
        .count_out(count)
    );

    // every core sees the same count
    genvar g;
    generate
        for (g = 0; g < CORES; g = g + 1) begin : g_core
            assign core_count_out[g*CNT_WIDTH +: CNT_WIDTH] = count; // see (R13)
        end
    endgenerate

    // decode wanted source from select field
    always_comb begin
        want = CCSC_SRC_FAST;
        cfg_bad = 1'b0;
        case (cfg_q.clock_source_select) // see (R1)
            `CCSC_SEL_FAST: want = CCSC_SRC_FAST;
            `CCSC_SEL_SLOW: want = CCSC_SRC_SLOW;
            `CCSC_SEL_XIN: begin
                if ({cfg_q.oscillator_gain_bit_high, cfg_q.oscillator_gain_bit_low}
                        == `CCSC_GAIN_XIN) begin
                    want = CCSC_SRC_XIN; // see (R6)
                end else begin
                    want = CCSC_SRC_XTAL; // see (R5)
                end
            end
            default: begin
                // taps need external reference and enabled pll
                if (cfg_q.pll_enable_bit && cfg_q.oscillator_enable_bit) begin
                    want = CCSC_SRC_PLL; // see (R3) see (R4)
                end else begin
                    want = src_q;
                    cfg_bad = 1'b1;
                end
            end
        endcase
    end

    // register writes and switch sequencing
    always_comb begin
        cfg_d = cfg_q;
        st_d = st_q;
        tmr_d = tmr_q;
        src_d = src_q;
        if (wr_in && addr_in == `CCSC_ADDR_CFG) begin
            cfg_d = ccsc_cfg_t'({1'b0, wdata_in[6:0]}); // see (R7) see (R1)
        end
        case (st_q)
            CCSC_ST_IDLE: begin
                if (want != src_q) begin
                    st_d = CCSC_ST_WAIT;
                    tmr_d = SW_W'(SWITCH_CYC - 1);
                end
            end
            CCSC_ST_WAIT: begin
                if (want == src_q) begin
                    st_d = CCSC_ST_IDLE;
                end else if (tmr_q == '0) begin
                    src_d = want; // see (R9)
                    st_d = CCSC_ST_IDLE;
                end else begin
                    tmr_d = tmr_q - 1'b1;
                end
            end
            default: st_d = CCSC_ST_IDLE;
        endcase
    end

    // read data, one cycle after strobe
    always_comb begin
        rdata_d = 32'h0;
        if (rd_in) begin
            case (addr_in)
                `CCSC_ADDR_CFG: rdata_d = {24'h0, cfg_q}; // see (R10)
                `CCSC_ADDR_CNT: rdata_d = count; // see (R13)
                `CCSC_ADDR_STAT: rdata_d = {27'h0, cfg_bad, switching_out, src_q};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cfg_q <= ccsc_cfg_t'(`CCSC_CFG_RESET); // see (R2)
            src_q <= CCSC_SRC_FAST; // see (R2)
            st_q <= CCSC_ST_IDLE;
            tmr_q <= '0;
            rdata_q <= 32'h0;
        end else begin
            cfg_q <= cfg_d;
            src_q <= src_d;
            st_q <= st_d;
            tmr_q <= tmr_d;
            rdata_q <= rdata_d;
        end
    end

    // oscillator and pll drive straight from configuration
    assign oscillator_enable_out = cfg_q.oscillator_enable_bit; // see (R8)
    assign oscillator_gain_out = {cfg_q.oscillator_gain_bit_high, cfg_q.oscillator_gain_bit_low};
    // output pin driven whenever the oscillator is enabled with nonzero gain, in any select mode
    assign oscillator_output_pin_oe_n_out = !(cfg_q.oscillator_enable_bit &&
        oscillator_gain_out != `CCSC_GAIN_XIN); // see (R6)
    assign pll_enable_out = cfg_q.pll_enable_bit && cfg_q.oscillator_enable_bit; // see (R3)
    assign pll_tap_out = cfg_q.clock_source_select - `CCSC_SEL_TAP1; // see (R4)
    assign pll_reference_out = cfg_q.oscillator_enable_bit; // see (R5)
    assign clock_source_out = src_q;
    assign switching_out = (st_q == CCSC_ST_WAIT);
    assign config_error_out = cfg_bad;
    assign rdata_out = rdata_q;
endmodule

/* File: design/ccsc_consts.svh */
// Overview of operation
// (R1) clock byte: bit7 zero, bit6 pll enable, bit5 osc enable, 4:3 gain, 2:0 select
// (R2) out of reset the fast internal oscillator drives the system clock
// (R3) internal oscillators never pass the pll; pll taps need external or crystal
// (R4) pll multiplies the reference by 16; system clock uses the chosen tap
// (R5) crystal without tap keeps pll off and runs at crystal rate; pll_enable_out still follows bits 6 and 5 in crystal mode
// (R6) external input mode uses input pin only; output pin stays undriven
// (R7) software writes a new mode byte at run time and the clock follows
// (R8) software enables oscillator and pll, waits 10 ms, then changes select
// (R9) source switchover completes about 75 us after a select change
// (R10) a read returns the raw stored configuration byte
// (R11) one shared 32-bit counter increments every system clock cycle
// (R12) counter has no defined reset value and just keeps counting
// (R13) counter is read-only and readable by every core at once
// (R14) counter wraps to zero at its maximum with no flag
`ifndef CCSC_CONSTS_SVH
`define CCSC_CONSTS_SVH
`define CCSC_ADDR_CFG 4'h0
`define CCSC_ADDR_CNT 4'h4
`define CCSC_ADDR_STAT 4'h8
`define CCSC_CFG_RESET 8'h00
`define CCSC_BIT_PLL 6
`define CCSC_BIT_OSC 5
`define CCSC_SEL_FAST 3'h0
`define CCSC_SEL_SLOW 3'h1
`define CCSC_SEL_XIN 3'h2
`define CCSC_SEL_TAP1 3'h3
`define CCSC_GAIN_XIN 2'h0
`define CCSC_PLL_MULT 16
`define CCSC_CLK_MHZ 125
`define CCSC_SETTLE_MS 10
`define CCSC_SWITCH_US 75
`define CCSC_SWITCH_CYC ((`CCSC_SWITCH_US * `CCSC_CLK_MHZ))
`define CCSC_SETTLE_CYC ((`CCSC_SETTLE_MS * 1000 * `CCSC_CLK_MHZ))
`endif

/* File: design/ccsc_pkg.sv */
package ccsc_pkg;
    // decoded view of the configuration byte
    typedef struct packed {
        logic zero;
        logic pll_enable_bit;
        logic oscillator_enable_bit;
        logic oscillator_gain_bit_high;
        logic oscillator_gain_bit_low;
        logic [2:0] clock_source_select;
    } ccsc_cfg_t;
    // active clock source
    typedef enum logic [2:0] {
        CCSC_SRC_FAST = 3'h0,
        CCSC_SRC_SLOW = 3'h1,
        CCSC_SRC_XIN = 3'h2,
        CCSC_SRC_XTAL = 3'h3,
        CCSC_SRC_PLL = 3'h4
    } ccsc_src_t;
    // switchover sequencer
    typedef enum logic [1:0] {
        CCSC_ST_IDLE = 2'b00,
        CCSC_ST_WAIT = 2'b01
    } ccsc_state_t;
endpackage

/* File: design/ccsc_counter.sv */
`timescale 1ns/10ps
`include "ccsc_consts.svh"
// free-running system counter
module ccsc_counter #(
    parameter int WIDTH = 32
) (
    // clock
    input wire logic clk_in,
    // count value
    output logic [WIDTH-1:0] count_out
);
    // power-up value carries no meaning; a known one keeps simulation free of unknowns
    logic [WIDTH-1:0] cnt_q = '0;
    logic [WIDTH-1:0] cnt_d;

    initial begin
        if (WIDTH < 1) $error("bad width");
    end

    // increment, wrapping silently
    always_comb begin
        cnt_d = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1}; // see (R11) see (R14)
    end

    // no reset: starts from its initial zero and keeps counting through reset
    always_ff @(posedge clk_in) begin
        cnt_q <= cnt_d; // see (R12)
    end

    assign count_out = cnt_q; // see (R13)
endmodule

/* File: verif/ccsc_top_monitor.sv */
`timescale 1ns/10ps
// mode decode, switchover and counter checks
module ccsc_top_monitor #(
    parameter int CNT_WIDTH = 32,
    parameter int CORES = 8
) (
    // clock and register port
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    // mode and counter outputs
    input wire logic pll_enable_out,
    input wire logic [2:0] pll_tap_out,
    input wire logic [2:0] clock_source_out,
    input wire logic switching_out,
    input wire logic config_error_out,
    input wire logic [CORES*CNT_WIDTH-1:0] core_count_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // write to the configuration byte
    wire cw = wr_in && addr_in == 4'h0;
    chk_pll_follow: assert property (cw |=> pll_enable_out == &$past(wdata_in[6:5]))
        else $error("pll enable");
    chk_tap_map: assert property (cw && wdata_in[2:0] > 3'h2 |=>
        pll_tap_out == $past(wdata_in[2:0]) - 3'h3) else $error("tap");
    chk_tap_error: assert property (cw && wdata_in[2:0] > 3'h2 && !(&wdata_in[6:5]) |=>
        config_error_out) else $error("cfg error");
    chk_reset_fast: assert property ($rose(rst_n_in) |-> clock_source_out == 3'h0)
        else $error("reset source");
    chk_switch_time: assert property ($rose(switching_out) |-> ##[1:8] !switching_out)
        else $error("switch time");
    chk_src_change: assert property ($changed(clock_source_out) |-> $past(switching_out))
        else $error("source change");
    chk_cnt_step: assert property (core_count_out[CNT_WIDTH-1:0] ==
        $past(core_count_out[CNT_WIDTH-1:0]) + 1'b1) else $error("count step");
    chk_cores_same: assert property (core_count_out ==
        {CORES{core_count_out[CNT_WIDTH-1:0]}}) else $error("core copy");
    // main scenarios
    cover property ($fell(switching_out) && clock_source_out == 3'h4);
    cover property ($fell(switching_out) && clock_source_out == 3'h3);
    cover property (config_error_out);
endmodule
bind ccsc_top ccsc_top_monitor #(.CNT_WIDTH(CNT_WIDTH), .CORES(CORES)) mon (.clk_in, .rst_n_in,
    .addr_in, .wdata_in, .wr_in, .pll_enable_out, .pll_tap_out, .clock_source_out,
    .switching_out, .config_error_out, .core_count_out);

/* File: verif/ccsc_xtal_model.sv */
`timescale 1ns/10ps
// crystal on the oscillator pins
module ccsc_xtal_model (
    // pin controls
    input wire logic enable_in,
    input wire logic oe_n_in,
    // input pin level
    output logic xi_out
);
    // swings only while the output pin is driven, else rests low
    initial xi_out = 1'b0;
    always #20 xi_out = (enable_in && !oe_n_in) ? !xi_out : 1'b0;
endmodule

/* File: verif/ccsc_testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [31:0] wdata_in = 32'h0;
    wire [31:0] rdata_out;
    wire [255:0] cnt;
    wire [1:0] gain;
    wire [2:0] tap, src;
    wire osc_en, oe_n, pll_en, pll_ref, sw, err, xi;
    int bad_count = 0;
    int checks = 0;
    // design with a short switchover count
    ccsc_top #(.SWITCH_CYC(5)) dut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .oscillator_enable_out(osc_en), .oscillator_gain_out(gain),
        .oscillator_output_pin_oe_n_out(oe_n), .pll_enable_out(pll_en), .pll_tap_out(tap),
        .pll_reference_out(pll_ref), .clock_source_out(src), .switching_out(sw),
        .config_error_out(err), .core_count_out(cnt));
    ccsc_xtal_model xtal (.enable_in(osc_en), .oe_n_in(oe_n), .xi_out(xi));
    // 125 mhz clock
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    task automatic settle;
        repeat (2) @(posedge clk_in);
        for (int n = 0; n < 30 && sw !== 1'b0; n++) @(posedge clk_in);
        #1 chk("switching", 32'h0, {31'h0, sw});
    endtask
    task automatic do_reset;
        rst_n_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
    endtask
    task automatic t_modes;
        logic [7:0] m [11] = '{8'h00, 8'h01, 8'h02, 8'h2a, 8'h32, 8'h3a, 8'h63, 8'h6c, 8'h75,
            8'h7e, 8'h67};
        logic [31:0] d;
        logic [2:0] s;
        foreach (m[i]) begin
            wr(4'h0, {24'h0, m[i] & 8'hf8});
            settle();
            wr(4'h0, {24'h0, m[i]});
            settle();
            rd(4'h0, d);
            chk("cfg read", {24'h0, m[i]}, d);
            s = m[i][2:0];
            chk("source", s > 3'h2 ? 32'h4 : {29'h0, s + {2'h0, s == 3'h2 && m[i][4:3] != 2'h0}},
                {29'h0, src});
            chk("pins", {27'h0, m[i][6:3], m[i][4:3] == 2'h0}, {27'h0, pll_en, osc_en, gain,
                oe_n});
            if (s > 3'h2) chk("tap", {29'h0, s - 3'h3}, {29'h0, tap});
            chk("pll reference", {31'h0, m[i][5]}, {31'h0, pll_ref});
        end
        $display("modes done");
    endtask
    task automatic t_refuse;
        logic [31:0] d;
        wr(4'h0, 32'haa);
        wr(4'h4, 32'h0);
        wr(4'h8, 32'hff);
        rd(4'h0, d);
        chk("bit7", 32'h2a, d);
        rd(4'hc, d);
        chk("unmapped", 32'h0, d);
        settle();
        wr(4'h0, 32'h43);
        #1 chk("cfg error", 32'h1, {31'h0, err});
        repeat (10) @(posedge clk_in);
        #1 chk("held source", 32'h3, {29'h0, src});
        rd(4'h8, d);
        chk("status", 32'h13, d);
        $display("refuse done");
    endtask
    task automatic t_cnt;
        logic [31:0] a, b;
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= 4'h4;
        @(posedge clk_in);
        #1 a = rdata_out;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 b = rdata_out;
        chk("count step", a + 32'h1, b);
        chk("core copy", cnt[31:0], cnt[255:224]);
        do_reset();
        rd(4'h4, b);
        chk("count kept", 32'h17, b - a);
        chk("reset source", 32'h0, {29'h0, src});
        $display("counter done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        do_reset();
        t_modes();
        t_refuse();
        t_cnt();
        report_and_stop();
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge clk_in);
        bad_count++;
        report_and_stop();
    end
endmodule
